/* src/foc_defines.svh */
// Purpose: shared constants of the flash once/erase/key command sequencer
// Assumes: command bytes are packed little end first, byte n at bits [8n+7:8n]
// Notes:   encodings of the security and backdoor-enable fields are plain defaults
`ifndef FOC_DEFINES_SVH
`define FOC_DEFINES_SVH

// ****************************************************************
// command codes held in command byte zero
// ****************************************************************
`define FOC_CODE_ONCE    8'h43
`define FOC_CODE_ERASE   8'h44
`define FOC_CODE_KEY     8'h45

// ****************************************************************
// command byte layout and one-time area shape
// ****************************************************************
`define FOC_CMD_BYTES    12
`define FOC_REC_COUNT    16
`define FOC_REC_BYTES    4
`define FOC_REC_MAX      8'h0F
`define FOC_IDX_W        4
`define FOC_KEY_BYTES    8
`define FOC_ERASED_WORD  32'hFFFF_FFFF

// ****************************************************************
// security and backdoor-enable field encodings, reset values
// ****************************************************************
`define FOC_SEC_W        2
`define FOC_SEC_UNSECURE 2'h2
`define FOC_SEC_RESET    2'h3
`define FOC_BACKDOOR_ENABLE_FIELD_ON     2'h2

`endif

/* src/foc_pkg.sv */
// Purpose: types of the flash once/erase/key command sequencer
// Assumes: nothing beyond the defines header
// Notes:   array operation codes are handed to the flash array side
package foc_pkg;

  // ****************************************************************
  // array operations requested from the flash array
  // ****************************************************************
  typedef enum logic [2:0] {
    FOC_OP_READ_REC,   // read one record of the one-time area
    FOC_OP_PROG_REC,   // program one record of the one-time area
    FOC_OP_ERASE_ALL,  // erase whole program array and config field
    FOC_OP_VERIFY_ALL, // verify whole array reads erased
    FOC_OP_PROG_SEC    // program stored security byte
  } foc_op_e;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    FOC_S_IDLE,
    FOC_S_ONCE_CHK,
    FOC_S_ONCE_PRG,
    FOC_S_ONCE_VFY,
    FOC_S_ERASE,
    FOC_S_ERASE_VFY,
    FOC_S_SEC_PRG,
    FOC_S_FIN
  } foc_state_e;

endpackage : foc_pkg

/* src/foc_sync.sv */
// Purpose: two-flop level synchroniser for a pin input
// Assumes: input is asynchronous to clk_i
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module foc_sync (
  input  logic clk_i,  // system clock
  input  logic rst_i,  // synchronous reset, active high
  input  logic d_i,    // asynchronous level
  output logic q_o     // synchronised level
);

  logic meta_reg;
  logic sync_reg;

  // ****************************************************************
  // two register stages
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule : foc_sync

/* src/foc_key_check.sv */
// Purpose: compares a supplied backdoor key with the stored comparison key
// Assumes: key byte i comes from command byte 4+i, config byte k at bits [8k+7:8k]
// Notes:   purely combinational, result is registered by the sequencer
`timescale 1ns/1ps
`include "foc_defines.svh"
module foc_key_check #(
  parameter int KEY_BYTES = `FOC_KEY_BYTES
) (
  input  logic [8*KEY_BYTES-1:0] key_i,     // supplied key bytes
  input  logic [8*KEY_BYTES-1:0] cfg_key_i, // stored comparison key by offset
  output logic                   match_o,   // every byte equal
  output logic                   trivial_o  // key all zeros or all ones
);

  logic [KEY_BYTES-1:0] eq;

  // ****************************************************************
  // per byte compare, offsets reversed inside each group of four
  // ****************************************************************
  for (genvar i = 0; i < KEY_BYTES; i++) begin : g_byte
    localparam int OFS = (i / 4) * 4 + 3 - (i % 4);
    assign eq[i] = (key_i[8*i +: 8] == cfg_key_i[8*OFS +: 8]);
  end

  // whole-key results
  assign match_o   = &eq;
  assign trivial_o = (key_i == '0) || (key_i == '1);

endmodule : foc_key_check

/* src/foc_seq.sv */
// Purpose: executes the one-time record program, full erase, external erase and key verify commands
// Assumes: array side answers each request with one ack pulse; same-clock inputs except ext_erase_i
// Notes:   completion flag low from launch until the command ends
`timescale 1ns/1ps
`include "foc_defines.svh"
module foc_seq (
  input  logic                          clk_i,                    // system clock, 50 MHz
  input  logic                          rst_i,                    // synchronous reset, active high
  input  logic [8*`FOC_CMD_BYTES-1:0]   command_bytes_i,          // command bytes, byte 0 lowest
  input  logic                          launch_i,                 // pulse: clear completion flag
  input  logic                          err_clear_i,              // pulse: clear access and protect flags
  input  logic                          special_mode_i,           // special operating mode
  input  logic                          protect_any_i,            // some array region protected
  input  logic [`FOC_SEC_W-1:0]         sec_init_i,               // security field from stored byte
  input  logic [`FOC_SEC_W-1:0]         backdoor_enable_field_i,  // backdoor enable field
  input  logic [8*`FOC_KEY_BYTES-1:0]   cfg_key_i,                // stored comparison key
  input  logic                          ext_erase_i,              // external full erase pin
  input  logic                          arr_ack_i,                // array operation done pulse
  input  logic [31:0]                   arr_rdata_i,              // record read data
  input  logic                          arr_fail_i,               // erase verify failed, with ack
  output logic                          cmd_complete_flag_o,      // command complete
  output logic                          access_error_flag_o,      // access error
  output logic                          protect_violation_flag_o, // protection violation
  output logic                          verify_fail_status_o,     // verify failure
  output logic                          external_erase_request_o, // external erase running
  output logic [`FOC_SEC_W-1:0]         security_state_o,         // security state field
  output logic                          read_invalid_o,           // array reads return invalid data
  output logic                          arr_req_o,                // array operation request
  output foc_pkg::foc_op_e              arr_op_o,                 // array operation
  output logic [`FOC_IDX_W-1:0]         arr_idx_o,                // record index
  output logic [31:0]                   arr_wdata_o               // record or security data
);
  import foc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  foc_state_e            state_reg,    state_next;
  foc_op_e               op_reg,       op_next;
  logic                  req_reg,      req_next;
  logic [`FOC_IDX_W-1:0] idx_reg,      idx_next;
  logic [31:0]           wdata_reg,    wdata_next;
  logic                  done_reg,     done_next;
  logic                  acc_reg,      acc_next;
  logic                  prot_reg,     prot_next;
  logic                  vfail_reg,    vfail_next;
  logic                  ext_reg,      ext_next;
  logic [`FOC_SEC_W-1:0] sec_reg,      sec_next;
  logic                  locked_reg,   locked_next;
  logic                  loaded_reg,   loaded_next;
  logic                  rdinv_reg,    rdinv_next;
  logic                  ext_prev_reg;
  logic                  acc_set;
  logic                  prot_set;
  logic                  ext_sync;
  logic                  ext_rise;
  logic                  key_match;
  logic                  key_trivial;
  logic                  go;
  logic                  allowed;
  logic [7:0]            code;

  // external erase pin into the clock domain
  foc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (ext_erase_i),
    .q_o   (ext_sync)
  );

  // key comparison on command bytes 4 to 11
  foc_key_check #(.KEY_BYTES(`FOC_KEY_BYTES)) u_key (
    .key_i     (command_bytes_i[8*`FOC_CMD_BYTES-1:32]),
    .cfg_key_i (cfg_key_i),
    .match_o   (key_match),
    .trivial_o (key_trivial)
  );

  // launch qualification
  assign code     = command_bytes_i[7:0];
  assign ext_rise = ext_sync && !ext_prev_reg;
  assign go       = launch_i && done_reg && loaded_reg && (state_reg == FOC_S_IDLE) && !ext_rise;
  assign allowed  = (sec_reg == `FOC_SEC_UNSECURE) ||
                    (special_mode_i && code == `FOC_CODE_ERASE) ||  // secure special mode: full erase only
                    (!special_mode_i && code == `FOC_CODE_KEY);     // secure normal mode: backdoor key only

  // ****************************************************************
  // next-state and flag logic
  // ****************************************************************
  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    idx_next    = idx_reg;
    wdata_next  = wdata_reg;
    done_next   = done_reg;
    vfail_next  = vfail_reg;
    ext_next    = ext_reg;
    sec_next    = sec_reg;
    locked_next = locked_reg;
    loaded_next = loaded_reg;
    acc_set     = 1'b0;
    prot_set    = 1'b0;
    unique case (state_reg)
      FOC_S_IDLE: begin
        if (!loaded_reg) begin
          sec_next    = sec_init_i;   // security field from stored byte
          loaded_next = 1'b1;
          done_next   = 1'b1;
        end else if (ext_rise && done_reg) begin
          done_next  = 1'b0;
          vfail_next = 1'b0;
          ext_next   = 1'b1;
          op_next    = FOC_OP_ERASE_ALL;
          state_next = FOC_S_ERASE;
        end else if (go) begin
          done_next  = 1'b0;
          vfail_next = 1'b0;
          state_next = FOC_S_FIN;
          if (!allowed) begin
            acc_set = 1'b1;
          end else if (code == `FOC_CODE_ONCE) begin
            if (command_bytes_i[15:8] > `FOC_REC_MAX) begin
              acc_set = 1'b1;
            end else begin
              idx_next   = command_bytes_i[8 +: `FOC_IDX_W];
              wdata_next = command_bytes_i[63:32];
              op_next    = FOC_OP_READ_REC;
              state_next = FOC_S_ONCE_CHK;
            end
          end else if (code == `FOC_CODE_ERASE) begin
            if (protect_any_i) begin
              prot_set = 1'b1;
            end else begin
              op_next    = FOC_OP_ERASE_ALL;
              state_next = FOC_S_ERASE;
            end
          end else if (code == `FOC_CODE_KEY) begin
            if (backdoor_enable_field_i != `FOC_BACKDOOR_ENABLE_FIELD_ON) begin
              acc_set = 1'b1;
            end else if (locked_reg || key_trivial) begin
              acc_set = 1'b1;
            end else if (key_match) begin
              sec_next = `FOC_SEC_UNSECURE;
            end else begin
              locked_next = 1'b1;
              acc_set     = 1'b1;
            end
          end else begin
            acc_set = 1'b1;           // unknown command code
          end
        end
      end
      FOC_S_ONCE_CHK: begin
        if (arr_ack_i) begin
          if (arr_rdata_i != `FOC_ERASED_WORD) begin
            acc_set    = 1'b1;
            state_next = FOC_S_FIN;
          end else begin
            op_next    = FOC_OP_PROG_REC;
            state_next = FOC_S_ONCE_PRG;
          end
        end
      end
      FOC_S_ONCE_PRG: begin
        if (arr_ack_i) begin
          op_next    = FOC_OP_READ_REC;
          state_next = FOC_S_ONCE_VFY;
        end
      end
      FOC_S_ONCE_VFY: begin
        if (arr_ack_i) begin
          vfail_next = (arr_rdata_i != wdata_reg);
          state_next = FOC_S_FIN;
        end
      end
      FOC_S_ERASE: begin
        if (arr_ack_i) begin
          op_next    = FOC_OP_VERIFY_ALL;
          state_next = FOC_S_ERASE_VFY;
        end
      end
      FOC_S_ERASE_VFY: begin
        if (arr_ack_i) begin
          state_next = FOC_S_FIN;
          if (arr_fail_i) begin
            vfail_next = 1'b1;
          end else begin
            sec_next = `FOC_SEC_UNSECURE;
            if (ext_reg) begin
              op_next    = FOC_OP_PROG_SEC;
              wdata_next = 32'(`FOC_SEC_UNSECURE);
              state_next = FOC_S_SEC_PRG;
            end
          end
        end
      end
      FOC_S_SEC_PRG: begin
        if (arr_ack_i) begin
          state_next = FOC_S_FIN;
        end
      end
      FOC_S_FIN: begin
        done_next  = 1'b1;
        ext_next   = 1'b0;
        state_next = FOC_S_IDLE;
      end
    endcase
    // set wins over software clear
    acc_next   = acc_set || (acc_reg && !err_clear_i);
    prot_next  = prot_set || (prot_reg && !err_clear_i);
    req_next   = (state_next != FOC_S_IDLE) && (state_next != FOC_S_FIN);
    rdinv_next = (state_next == FOC_S_ONCE_CHK) || (state_next == FOC_S_ONCE_PRG) ||
                 (state_next == FOC_S_ONCE_VFY);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= FOC_S_IDLE;
      op_reg       <= FOC_OP_READ_REC;
      req_reg      <= 1'b0;
      idx_reg      <= '0;
      wdata_reg    <= '0;
      done_reg     <= 1'b0;
      acc_reg      <= 1'b0;
      prot_reg     <= 1'b0;
      vfail_reg    <= 1'b0;
      ext_reg      <= 1'b0;
      sec_reg      <= `FOC_SEC_RESET;
      locked_reg   <= 1'b0;
      loaded_reg   <= 1'b0;
      rdinv_reg    <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      req_reg      <= req_next;
      idx_reg      <= idx_next;
      wdata_reg    <= wdata_next;
      done_reg     <= done_next;
      acc_reg      <= acc_next;
      prot_reg     <= prot_next;
      vfail_reg    <= vfail_next;
      ext_reg      <= ext_next;
      sec_reg      <= sec_next;
      locked_reg   <= locked_next;
      loaded_reg   <= loaded_next;
      rdinv_reg    <= rdinv_next;
      ext_prev_reg <= ext_sync;
    end
  end

  // outputs straight from registers
  assign cmd_complete_flag_o      = done_reg;
  assign access_error_flag_o      = acc_reg;
  assign protect_violation_flag_o = prot_reg;
  assign verify_fail_status_o     = vfail_reg;
  assign external_erase_request_o = ext_reg;
  assign security_state_o         = sec_reg;
  assign read_invalid_o           = rdinv_reg;
  assign arr_req_o                = req_reg;
  assign arr_op_o                 = op_reg;
  assign arr_idx_o                = idx_reg;
  assign arr_wdata_o              = wdata_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_launch_drops_done: assert property (go |=> !done_reg && state_reg != FOC_S_IDLE)
    else $error("completion flag not held low after launch");
  a_mode_refused: assert property (go && !allowed |=> acc_reg && state_reg == FOC_S_FIN ##1 done_reg)
    else $error("forbidden command not refused");
  a_index_range: assert property (go && allowed && code == `FOC_CODE_ONCE &&
                                  command_bytes_i[15:8] > `FOC_REC_MAX |=> acc_reg && !req_reg)
    else $error("bad record index accepted");
  a_once_not_erased: assert property (state_reg == FOC_S_ONCE_CHK && arr_ack_i &&
                                      arr_rdata_i != `FOC_ERASED_WORD |=> acc_reg && !req_reg ##1 done_reg)
    else $error("non-erased record programmed");
  a_once_verify: assert property (state_reg == FOC_S_ONCE_VFY && arr_ack_i &&
                                  arr_rdata_i != wdata_reg |=> vfail_reg ##1 done_reg && vfail_reg)
    else $error("read-back mismatch not reported");
  a_read_invalid: assert property (state_reg inside {FOC_S_ONCE_CHK, FOC_S_ONCE_PRG, FOC_S_ONCE_VFY}
                                   |-> rdinv_reg && !done_reg)
    else $error("reads not marked invalid during record programming");
  a_erase_protect: assert property (go && allowed && code == `FOC_CODE_ERASE && protect_any_i
                                    |=> prot_reg && !req_reg && state_reg == FOC_S_FIN)
    else $error("protected full erase not aborted");
  a_erase_unsecure: assert property (state_reg == FOC_S_ERASE_VFY && arr_ack_i && !arr_fail_i
                                     |=> sec_reg == `FOC_SEC_UNSECURE)
    else $error("passing erase did not unsecure");
  a_ext_no_protect: assert property (ext_reg && !$past(prot_reg) |-> !prot_reg)
    else $error("external erase raised protection flag");
  a_key_locked: assert property (go && allowed && code == `FOC_CODE_KEY && locked_reg
                                 |=> acc_reg && $stable(sec_reg) ##1 done_reg)
    else $error("key command ran after mismatch");
  a_key_trivial: assert property (go && allowed && code == `FOC_CODE_KEY && key_trivial |=> acc_reg)
    else $error("trivial key accepted");

  c_once_done:  cover property (state_reg == FOC_S_ONCE_VFY && arr_ack_i ##2 done_reg);
  c_erase_done: cover property (state_reg == FOC_S_ERASE_VFY && arr_ack_i && !arr_fail_i);
  c_ext_erase:  cover property (ext_reg && state_reg == FOC_S_SEC_PRG);
  c_key_match:  cover property (go && code == `FOC_CODE_KEY && key_match && !key_trivial);

endmodule : foc_seq

/* tb/foc_array_model.sv */
// Purpose: behavioural flash array and one-time area facing the command sequencer
// Assumes: one ack pulse per request, answered at once or after five waits
// Notes:   released read lines toggle every cycle so stale data never looks valid
`timescale 1ns/1ps
module foc_array_model (
  input  logic             clk_i,     // system clock
  input  logic             rst_i,     // synchronous reset, active high
  input  logic             req_i,     // operation request
  input  foc_pkg::foc_op_e op_i,      // requested operation
  input  logic [3:0]       idx_i,     // record index
  input  logic [31:0]      wdata_i,   // record data
  input  logic             slow_i,    // answer after five wait cycles
  input  logic             corrupt_i, // programming loses bit 0
  input  logic             vfail_i,   // erase verify reports failure
  output logic             ack_o,     // operation done pulse
  output logic [31:0]      rdata_o,   // record read data
  output logic             fail_o     // erase verify result
);
  import foc_pkg::*;
  logic [31:0] mem [16];
  logic [2:0]  wait_reg;
  // records start erased; nothing here ever erases them again
  initial begin
    ack_o    = 1'b0;
    rdata_o  = 32'h0000_0000;
    fail_o   = 1'b0;
    wait_reg = 3'h0;
    foreach (mem[i]) mem[i] = 32'hFFFF_FFFF;
  end
  // one answer per request, programming only clears bits
  always @(posedge clk_i) begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    fail_o  <= ~fail_o;
    if (rst_i || !req_i || ack_o) begin
      wait_reg <= 3'h0;
    end else if (wait_reg < (slow_i ? 3'h5 : 3'h0)) begin
      wait_reg <= wait_reg + 3'h1;
    end else begin
      ack_o <= 1'b1;
      case (op_i)
        FOC_OP_READ_REC:   rdata_o <= mem[idx_i];
        FOC_OP_PROG_REC:   mem[idx_i] <= mem[idx_i] & {wdata_i[31:1], wdata_i[0] & !corrupt_i};
        FOC_OP_VERIFY_ALL: fail_o <= vfail_i;
        default:           ;
      endcase
    end
  end
endmodule : foc_array_model

/* tb/testbench.sv */
// Purpose: self-checking bench of the once, erase, external erase and key commands
// Assumes: array model answers requests; inputs change on rising edges
// Notes:   the secure start is reloaded by three further resets in mid-run
`timescale 1ns/1ps
module testbench;
  import foc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, launch_i = 1'b0, err_clear_i = 1'b0, ext_erase_i = 1'b0;
  logic        special_mode_i = 1'b0, protect_any_i = 1'b0, slow = 1'b0, corrupt = 1'b0, vfail = 1'b0, saw;
  logic        arr_ack_i, arr_fail_i, cmd_complete_flag_o, access_error_flag_o, protect_violation_flag_o;
  logic        verify_fail_status_o, external_erase_request_o, read_invalid_o, arr_req_o;
  logic [1:0]  sec_init_i = 2'h3, backdoor_enable_field_i = 2'h2, security_state_o;
  logic [3:0]  arr_idx_o;
  logic [31:0] arr_rdata_i, arr_wdata_o;
  logic [63:0] cfg_key_i = 64'h8877_6655_4433_2211;
  logic [95:0] command_bytes_i = 96'h0;
  foc_op_e     arr_op_o;
  int          n_mismatch = 0, total_checks = 0, cycles = 0;
  // stored key seen through offsets 3,2,1,0 then 7,6,5,4
  localparam logic [63:0] KEY_OK = 64'h5566_7788_1122_3344;

  always #10 clk_i = ~clk_i;

  foc_seq dut (
    .clk_i, .rst_i, .command_bytes_i, .launch_i, .err_clear_i, .special_mode_i, .protect_any_i,
    .sec_init_i, .backdoor_enable_field_i, .cfg_key_i, .ext_erase_i, .arr_ack_i, .arr_rdata_i,
    .arr_fail_i, .cmd_complete_flag_o, .access_error_flag_o, .protect_violation_flag_o,
    .verify_fail_status_o, .external_erase_request_o, .security_state_o, .read_invalid_o,
    .arr_req_o, .arr_op_o, .arr_idx_o, .arr_wdata_o);
  foc_array_model arr (
    .clk_i, .rst_i, .req_i(arr_req_o), .op_i(arr_op_o), .idx_i(arr_idx_o), .wdata_i(arr_wdata_o),
    .slow_i(slow), .corrupt_i(corrupt), .vfail_i(vfail), .ack_o(arr_ack_i), .rdata_o(arr_rdata_i),
    .fail_o(arr_fail_i));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("reset security", {cmd_complete_flag_o, security_state_o}, 3'b111);
  endtask : do_reset

  // clear flags, launch one command, optionally relaunch while busy, wait for completion
  task automatic do_cmd(input logic [7:0] code, input logic [7:0] idx, input logic [63:0] data, input bit poke);
    int n;
    n = 0;
    saw = 1'b0;
    @(posedge clk_i);
    err_clear_i <= 1'b1;
    @(posedge clk_i);
    err_clear_i     <= 1'b0;
    command_bytes_i <= {data, 16'h0000, idx, code};
    launch_i        <= 1'b1;
    @(posedge clk_i);
    launch_i <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
      saw |= read_invalid_o;
      launch_i <= poke && n == 2;
    end while (cmd_complete_flag_o !== 1'b1 && n < 300);
    check("finished", n < 300, 1);
    if (poke) begin
      repeat (2) @(posedge clk_i);
      check("no relaunch", cmd_complete_flag_o, 1);
    end
  endtask : do_cmd

  task automatic t_secure;
    do_cmd(8'h43, 8'h00, 64'h0, 0);
    check("once secure", access_error_flag_o, 1);
    check("rec0 untouched", arr.mem[0], 32'hFFFF_FFFF);
    special_mode_i <= 1'b1;
    do_cmd(8'h45, 8'h00, KEY_OK, 0);
    check("key special", {access_error_flag_o, security_state_o}, 3'b111);
  endtask : t_secure

  task automatic t_ext;
    int n;
    n = 0;
    saw = 1'b0;
    protect_any_i   <= 1'b1;
    command_bytes_i <= 96'h0;
    err_clear_i     <= 1'b1;
    @(posedge clk_i);
    err_clear_i <= 1'b0;
    ext_erase_i <= 1'b1;
    do @(posedge clk_i); while (external_erase_request_o !== 1'b1 && ++n < 20);
    ext_erase_i <= 1'b0;
    do begin
      @(posedge clk_i);
      saw |= arr_req_o && arr_op_o == FOC_OP_PROG_SEC;
      check("busy during ext", cmd_complete_flag_o & external_erase_request_o, 0);
    end while (external_erase_request_o === 1'b1 && ++n < 200);
    check("ext done", {n < 200, cmd_complete_flag_o}, 2'b11);
    check("ext flags", {protect_violation_flag_o, verify_fail_status_o}, 0);
    check("ext security", {saw, security_state_o}, 3'b110);
    protect_any_i <= 1'b0;
  endtask : t_ext

  task automatic t_erase;
    protect_any_i <= 1'b1;
    do_cmd(8'h44, 8'h00, 64'h0, 0);
    check("erase protected", {protect_violation_flag_o, security_state_o}, 3'b111);
    protect_any_i <= 1'b0;
    vfail         <= 1'b1;
    do_cmd(8'h44, 8'h00, 64'h0, 0);
    check("erase verify", {verify_fail_status_o, security_state_o}, 3'b111);
    vfail <= 1'b0;
    slow  <= 1'b1;
    do_cmd(8'h44, 8'h00, 64'h0, 1);
    check("erase ok", {access_error_flag_o, protect_violation_flag_o, verify_fail_status_o}, 0);
    check("erase unsecures", security_state_o, 2'h2);
    slow           <= 1'b0;
    special_mode_i <= 1'b0;
  endtask : t_erase

  task automatic t_once;
    do_cmd(8'h43, 8'h0F, 64'h1234_5679, 0);
    check("once ok", {access_error_flag_o, verify_fail_status_o, saw}, 3'b001);
    check("rec15", arr.mem[15], 32'h1234_5679);
    do_cmd(8'h43, 8'h0F, 64'h0, 0);
    check("once twice", {access_error_flag_o, arr.mem[15]}, 33'h1_1234_5679);
    do_cmd(8'h43, 8'h10, 64'h0, 0);
    check("bad index", access_error_flag_o, 1);
    corrupt <= 1'b1;
    do_cmd(8'h43, 8'h00, 64'hFFFF_0001, 0);
    check("once verify", verify_fail_status_o, 1);
    corrupt <= 1'b0;
  endtask : t_once

  task automatic t_key;
    do_reset();
    backdoor_enable_field_i <= 2'h0;
    do_cmd(8'h45, 8'h00, KEY_OK, 0);
    check("key disabled", access_error_flag_o, 1);
    backdoor_enable_field_i <= 2'h2;
    do_cmd(8'h45, 8'h00, 64'h0, 0);
    check("key zeros", access_error_flag_o, 1);
    do_cmd(8'h45, 8'h00, '1, 0);
    check("key ones", access_error_flag_o, 1);
    do_cmd(8'h45, 8'h00, KEY_OK, 0);
    check("key ok", {access_error_flag_o, security_state_o}, 3'b010);
    do_cmd(8'h45, 8'h00, KEY_OK ^ 64'h1, 0);
    check("key bad", access_error_flag_o, 1);
    do_cmd(8'h45, 8'h00, KEY_OK, 0);
    check("key locked", access_error_flag_o, 1);
    do_reset();
    do_cmd(8'h45, 8'h00, KEY_OK, 0);
    check("key after reset", {access_error_flag_o, security_state_o}, 3'b010);
  endtask : t_key

  initial begin
    do_reset();
    t_secure();
    t_ext();
    do_reset();
    t_erase();
    t_once();
    t_key();
    final_report();
  end
endmodule : testbench
